// file: dv/hpl_sink_model.sv
// Purpose: sink driving both detect pins
// Assumes: pins idle high while a sink is attached
// Notes:   one pulse at a time, started by the bench
`timescale 1ns/1ps
module hpl_sink_model #(
    parameter int TICK = 2 // aclk cycles per tick
) (
    input  wire logic aclk,   // core clock
    output logic      line_b, // port B pin
    output logic      line_c  // port C pin
);
    initial line_b = 1'b1;
    initial line_c = 1'b1;
    // unplug and sink notice look alike on the pin; only width differs
    task automatic pulse(input bit c, input int ticks);
        repeat (8) @(posedge aclk);
        if (c) line_c <= 1'b0;
        else line_b <= 1'b0;
        repeat (ticks * TICK) @(posedge aclk);
        line_b <= 1'b1;
        line_c <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask : pulse
endmodule : hpl_sink_model

// file: dv/tb_hpl_hotplug_detect.sv
// Purpose: self-checking bench for the hot-plug detector
// Assumes: TICK_CYCLES of 2 keeps pulses short
// Notes:   100 ms long pulses left out to bound run time
`timescale 1ns/1ps
module tb_hpl_hotplug_detect;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        port_b_hot_plug_detect_line, port_c_hot_plug_detect_line;
    logic        interrupt_status_vector_hotplug, irq;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [1:0]  sel_t [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [1:0]  st_t [5]  = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h1};
    int          wid_t [5] = '{3000, 4000, 5000, 5000, 7000};

    always #4 aclk = ~aclk;

    hpl_hotplug_detect #(.TICK_CYCLES(2)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .port_b_hot_plug_detect_line(port_b_hot_plug_detect_line),
        .port_c_hot_plug_detect_line(port_c_hot_plug_detect_line),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .interrupt_status_vector_hotplug(interrupt_status_vector_hotplug), .irq(irq)
    );
    hpl_sink_model #(.TICK(2)) u_sink (
        .aclk   (aclk),
        .line_b (port_b_hot_plug_detect_line),
        .line_c (port_c_hot_plug_detect_line)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // w: write, checks the response code; else read, checks the data
    task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        bit          pa, pd, pr, ta, td;
        int          t;
        logic [31:0] q;
        logic [1:0]  r;
        pa = 1'b1;
        pd = w;
        pr = 1'b1;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        // ready is sampled mid-cycle, where it is settled for the next edge
        while (pr && t < 1000) begin
            @(negedge aclk);
            t++;
            ta = pa && (w ? s_axi_awready : s_axi_arready);
            td = pd && s_axi_wready;
            pr = !(w ? s_axi_bvalid : s_axi_rvalid);
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) begin
                pa = 1'b0;
                {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            end
            if (td) begin
                pd = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (pr) n_errors++;
        chk(w ? 32'(r) : q, e);
        if (!w) chk(32'(r), 32'(hpl_pkg::HPL_RESP_OKAY));
        @(posedge aclk);
    endtask : bus

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, 4'h0, 32'h0, 32'h0);
        bus(1'b0, 4'hc, 32'h0, 32'h0);
        bus(1'b1, 4'h0, 32'hf0, 32'h0);
        bus(1'b0, 4'h0, 32'h0, 32'h10);
        bus(1'b1, 4'h4, 32'hf, 32'h2);
        u_sink.pulse(1'b1, 1000);
        bus(1'b0, 4'h4, 32'h0, 32'h0);
        bus(1'b1, 4'hc, 32'hf, 32'h0);
        u_sink.pulse(1'b0, 1000);
        bus(1'b0, 4'h0, 32'h0, 32'h11);
        chk(32'(interrupt_status_vector_hotplug), 32'h1);
        chk(32'(irq), 32'h1);
        u_sink.pulse(1'b0, 3000);
        bus(1'b0, 4'h0, 32'h0, 32'h13);
        bus(1'b1, 4'h0, 32'h11, 32'h0);
        bus(1'b0, 4'h0, 32'h0, 32'h12);
        bus(1'b1, 4'h0, 32'h12, 32'h0);
        chk(32'(interrupt_status_vector_hotplug), 32'h0);
        bus(1'b0, 4'h4, 32'h0, 32'h3);
        bus(1'b1, 4'h8, 32'h3, 32'h0);
        chk(32'(irq), 32'h0);
        bus(1'b1, 4'hc, 32'h0, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 4'h0, 32'h1310 | 32'(sel_t[i]) << 10, 32'h0);
            u_sink.pulse(1'b1, wid_t[i]);
            bus(1'b0, 4'h0, 32'h0, 32'h1010 | 32'(sel_t[i]) << 10 | 32'(st_t[i]) << 8);
            chk(32'(irq), 32'h0);
        end
        conclude();
    end

    initial begin
        repeat (90000) @(posedge aclk);
        n_errors++;
        conclude();
    end
endmodule : tb_hpl_hotplug_detect

// file: src/hpl_hotplug_detect.sv
// Purpose: hot-plug pulse detector for ports B and C with AXI4-Lite registers
// Assumes: aclk at 125 MHz, AXI master keeps one read and one write in flight
// Notes:   ctl 0x0, int status 0x4, int clear 0x8, int enable 0xc
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hpl_hotplug_detect #(
    parameter int unsigned TICK_CYCLES = hpl_pkg::HPL_TICK_CYCLES // cycles per tick
) (
    input  wire logic        aclk,                            // core clock
    input  wire logic        aresetn,                         // sync reset, active low
    input  wire logic        ce,                              // clock enable
    input  wire logic        port_b_hot_plug_detect_line,     // port B pin
    input  wire logic        port_c_hot_plug_detect_line,     // port C pin
    input  wire logic [3:0]  s_axi_awaddr,                    // write address
    input  wire logic        s_axi_awvalid,                   // write address valid
    output logic             s_axi_awready,                   // write address ready
    input  wire logic [31:0] s_axi_wdata,                     // write data
    input  wire logic [3:0]  s_axi_wstrb,                     // byte strobes
    input  wire logic        s_axi_wvalid,                    // write data valid
    output logic             s_axi_wready,                    // write data ready
    output logic [1:0]       s_axi_bresp,                     // write response
    output logic             s_axi_bvalid,                    // write response valid
    input  wire logic        s_axi_bready,                    // write response ready
    input  wire logic [3:0]  s_axi_araddr,                    // read address
    input  wire logic        s_axi_arvalid,                   // read address valid
    output logic             s_axi_arready,                   // read address ready
    output logic [31:0]      s_axi_rdata,                     // read data
    output logic [1:0]       s_axi_rresp,                     // read response
    output logic             s_axi_rvalid,                    // read data valid
    input  wire logic        s_axi_rready,                    // read data ready
    output logic             interrupt_status_vector_hotplug, // live OR of status
    output logic             irq                              // level interrupt
);
    localparam int NP = hpl_pkg::HPL_NPORT;
    localparam int TW = $clog2(TICK_CYCLES + 1);

    hpl_pkg::hpl_port_ctl_t ctl_r [NP];
    logic [31:0]            ctl_rd;
    logic [NP-1:0]          pins;
    logic [NP-1:0]          line_s;
    logic [NP-1:0]          evt_short;
    logic [NP-1:0]          evt_long;
    logic [2*NP-1:0]        evt_vec;
    logic [2*NP-1:0]        int_st_r;
    logic [2*NP-1:0]        int_en_r;
    logic [NP-1:0]          port_pend;
    logic [TW-1:0]          tick_cnt_r;
    logic                   tick;

    logic                   aw_got_r;
    logic [3:0]             awaddr_r;
    logic                   w_got_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   wr_do;
    logic                   wr_ctl;
    logic                   wr_clr;
    logic                   wr_en;
    logic                   rd_do;
    logic [31:0]            rd_word;
    logic [1:0]             rd_resp;
    logic [1:0]             wr_resp;
    logic                   bvalid_r;
    logic                   rvalid_r;

    assign pins = {port_c_hot_plug_detect_line, port_b_hot_plug_detect_line};

    // ---- measuring tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= '0;
        end else if (ce) begin
            if (tick) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + TW'(1);
            end
        end
    end

    assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

    // ---- per-port detection
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_port
            hpl_sync3 u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .pin     (pins[gi]),
                .q       (line_s[gi])
            );

            // only the buffer enable gates the line; port enable plays no part
            hpl_pulse_meas u_meas (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .ce        (ce),
                .tick      (tick),
                .enable    (ctl_r[gi].en),
                .line      (line_s[gi]),
                .thr       (hpl_pkg::hpl_thr(ctl_r[gi].sel)),
                .short_evt (evt_short[gi]),
                .long_evt  (evt_long[gi])
            );

            // attach, detach and sink alerts all land here by width only
            assign evt_vec[2*gi]     = evt_short[gi];
            assign evt_vec[2*gi + 1] = evt_long[gi];
            assign port_pend[gi]     = |ctl_r[gi].st;

            assign ctl_rd[gi*hpl_pkg::HPL_PORT_STRIDE +: hpl_pkg::HPL_PORT_STRIDE] =
                {3'h0, ctl_r[gi]};

            // status set beats a write-one clear in the same cycle
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ctl_r[gi] <= hpl_pkg::HPL_PORT_CTL_RST;
                end else if (ce) begin
                    if (wr_ctl && wstrb_r[gi]) begin
                        ctl_r[gi].en  <= wdata_r[gi*hpl_pkg::HPL_PORT_STRIDE + hpl_pkg::HPL_EN_BIT];
                        ctl_r[gi].sel <= wdata_r[gi*hpl_pkg::HPL_PORT_STRIDE + hpl_pkg::HPL_SEL_LSB +: 2];
                        ctl_r[gi].st  <= (ctl_r[gi].st
                                          & ~wdata_r[gi*hpl_pkg::HPL_PORT_STRIDE + hpl_pkg::HPL_ST_LSB +: 2])
                                         | {evt_long[gi], evt_short[gi]};
                    end else begin
                        ctl_r[gi].st <= ctl_r[gi].st | {evt_long[gi], evt_short[gi]};
                    end
                end
            end
        end
    endgenerate

    assign ctl_rd[31:NP*hpl_pkg::HPL_PORT_STRIDE] = '0;

    // no latching here: masking happens in later interrupt stages
    assign interrupt_status_vector_hotplug = |port_pend;

    // ---- interrupt block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_st_r <= hpl_pkg::HPL_INT_RST;
        end else if (ce) begin
            if (wr_clr && wstrb_r[0]) begin
                int_st_r <= (int_st_r & ~wdata_r[2*NP-1:0]) | evt_vec;
            end else begin
                int_st_r <= int_st_r | evt_vec;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_en_r <= hpl_pkg::HPL_INT_RST;
        end else if (ce && wr_en && wstrb_r[0]) begin
            int_en_r <= wdata_r[2*NP-1:0];
        end
    end

    assign irq = |(int_st_r & int_en_r);

    // ---- AXI4-Lite write path, address and data taken in any order
    // readies and valids drop with ce, so a frozen slave never shows a handshake it cannot take
    assign s_axi_awready = ce && !aw_got_r && !bvalid_r;
    assign s_axi_wready  = ce && !w_got_r && !bvalid_r;
    assign wr_do         = aw_got_r && w_got_r;
    assign wr_ctl        = wr_do && (awaddr_r == hpl_pkg::HPL_OFF_CTL);
    assign wr_clr        = wr_do && (awaddr_r == hpl_pkg::HPL_OFF_INT_CLR);
    assign wr_en         = wr_do && (awaddr_r == hpl_pkg::HPL_OFF_INT_EN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            awaddr_r <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_got_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_do) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // the status register is read-only, so a write to it is refused
    always_comb begin
        if (wr_ctl || wr_clr || wr_en) begin
            wr_resp = hpl_pkg::HPL_RESP_OKAY;
        end else begin
            wr_resp = hpl_pkg::HPL_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r    <= 1'b0;
            s_axi_bresp <= hpl_pkg::HPL_RESP_OKAY;
        end else if (ce) begin
            if (wr_do) begin
                bvalid_r    <= 1'b1;
                s_axi_bresp <= wr_resp;
            end else if (s_axi_bready) begin
                bvalid_r    <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r && ce;

    // ---- AXI4-Lite read path
    assign s_axi_arready = ce && !rvalid_r;
    assign rd_do         = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rd_resp = hpl_pkg::HPL_RESP_OKAY;
        case (s_axi_araddr)
            hpl_pkg::HPL_OFF_CTL:     rd_word = ctl_rd;
            hpl_pkg::HPL_OFF_INT_ST:  rd_word = {{(32-2*NP){1'b0}}, int_st_r};
            hpl_pkg::HPL_OFF_INT_CLR: rd_word = 32'h00000000;
            hpl_pkg::HPL_OFF_INT_EN:  rd_word = {{(32-2*NP){1'b0}}, int_en_r};
            default: begin
                rd_word = 32'h00000000;
                rd_resp = hpl_pkg::HPL_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r    <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= hpl_pkg::HPL_RESP_OKAY;
        end else if (ce) begin
            if (rd_do) begin
                rvalid_r    <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rready) begin
                rvalid_r    <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_r && ce;

    // ---- checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_pair;
        ce && aw_got_r && w_got_r;
    endsequence

    sequence s_clr_b_short;
        ce && wr_ctl && wstrb_r[0] && wdata_r[0] && !evt_short[0];
    endsequence

    a_hotplug_follows:
    assert property (ce && (|evt_vec) |=> interrupt_status_vector_hotplug)
        else $error("event did not reach hotplug bit");

    a_hotplug_live:
    assert property (ce && wr_ctl && (&wstrb_r[1:0]) && (wdata_r[9:8] == 2'h3) && (wdata_r[1:0] == 2'h3)
                     && !(|evt_vec) |=> !interrupt_status_vector_hotplug)
        else $error("hotplug bit held after full clear");

    a_short_sets_b:
    assert property (ce && evt_short[0] |=> ctl_r[0].st[0] && ctl_rd[0])
        else $error("port B short status not set");

    a_long_sets_c:
    assert property (ce && evt_long[1] |=> ctl_rd[9])
        else $error("port C long status not set");

    a_w1c_clears:
    assert property (s_clr_b_short |=> !ctl_r[0].st[0])
        else $error("write one did not clear status");

    a_w0_keeps:
    assert property (ce && wr_ctl && !wdata_r[1] && ctl_r[0].st[1] |=> ctl_r[0].st[1])
        else $error("write zero cleared status");

    a_reset_zero:
    assert property ($rose(aresetn) |-> ctl_rd == 32'h00000000 && !irq)
        else $error("control not zero after reset");

    a_reserved_quiet:
    assert property (ce && wr_ctl && wstrb_r[0] && (wdata_r[7:5] != 3'h0) |=> ctl_rd[7:5] == 3'h0)
        else $error("reserved bits took a write");

    a_enable_b:
    assert property (ce && wr_ctl && wstrb_r[0] |=> ctl_rd[4] == $past(wdata_r[4]))
        else $error("port B buffer enable not written");

    a_enable_c:
    assert property (ce && wr_ctl && wstrb_r[1] |=> ctl_rd[12] == $past(wdata_r[12]))
        else $error("port C buffer enable not written");

    a_tick_spacing:
    assert property (ce && tick |=> !tick)
        else $error("tick fired twice in a row");

    a_wr_answer:
    assert property (s_wr_pair |=> bvalid_r && !aw_got_r && !w_got_r)
        else $error("write response not raised");

    a_irq_level:
    assert property (ce && (|(evt_vec & int_en_r)) && !(wr_en && wstrb_r[0]) |=> irq)
        else $error("enabled event gave no interrupt");

    a_width_b:
    assert property (ce && wr_ctl && wstrb_r[0] |=> ctl_rd[3:2] == $past(wdata_r[3:2]))
        else $error("port B width select not written");

    a_width_c:
    assert property (ce && wr_ctl && wstrb_r[1] |=> ctl_rd[11:10] == $past(wdata_r[11:10]))
        else $error("port C width select not written");

    a_long_sets_b:
    assert property (ce && evt_long[0] |=> ctl_rd[1])
        else $error("port B long status not set");

    a_short_sets_c:
    assert property (ce && evt_short[1] |=> ctl_rd[8])
        else $error("port C short status not set");

    a_int_clear:
    assert property (ce && wr_clr && wstrb_r[0] && wdata_r[0] && !evt_vec[0] |=> !int_st_r[0])
        else $error("interrupt status not cleared");

    a_rd_answer:
    assert property (ce && rd_do |=> rvalid_r)
        else $error("read data not raised");
endmodule : hpl_hotplug_detect

// file: src/hpl_pkg.sv
// Purpose: constants and types of the hot-plug pulse detector
// Assumes: 125 MHz aclk, 1 us measuring tick
// Notes:   register offsets are byte addresses of aligned 32-bit words
package hpl_pkg;
    localparam int          HPL_NPORT       = 2;
    localparam int          HPL_ADDR_W      = 4;
    localparam logic [3:0]  HPL_OFF_CTL     = 4'h0;
    localparam logic [3:0]  HPL_OFF_INT_ST  = 4'h4;
    localparam logic [3:0]  HPL_OFF_INT_CLR = 4'h8;
    localparam logic [3:0]  HPL_OFF_INT_EN  = 4'hc;
    localparam int          HPL_PORT_STRIDE = 8;
    localparam int          HPL_ST_LSB      = 0;
    localparam int          HPL_SEL_LSB     = 2;
    localparam int          HPL_EN_BIT      = 4;
    localparam logic [1:0]  HPL_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  HPL_RESP_SLVERR = 2'h2;
    localparam logic [3:0]  HPL_INT_RST     = 4'h0;
    localparam int          HPL_CLK_NS      = 8;
    localparam int          HPL_TICK_NS     = 1000;
    localparam int          HPL_TICK_CYCLES = HPL_TICK_NS / HPL_CLK_NS;
    localparam real         HPL_TICKS_PER_MS = 1000.0;
    localparam real         HPL_T_SEL0_MS   = 2.0;
    localparam real         HPL_T_SEL1_MS   = 4.5;
    localparam real         HPL_T_SEL2_MS   = 6.0;
    localparam real         HPL_T_SEL3_MS   = 100.0;
    localparam int          HPL_THR_W       = 17;
    localparam logic [16:0] HPL_THR_SEL0    = 17'(int'(HPL_T_SEL0_MS * HPL_TICKS_PER_MS));
    localparam logic [16:0] HPL_THR_SEL1    = 17'(int'(HPL_T_SEL1_MS * HPL_TICKS_PER_MS));
    localparam logic [16:0] HPL_THR_SEL2    = 17'(int'(HPL_T_SEL2_MS * HPL_TICKS_PER_MS));
    localparam logic [16:0] HPL_THR_SEL3    = 17'(int'(HPL_T_SEL3_MS * HPL_TICKS_PER_MS));

    // one port's slice of the control register, bits [4:0] of its byte
    typedef struct packed {
        logic       en;
        logic [1:0] sel;
        logic [1:0] st;
    } hpl_port_ctl_t;

    localparam hpl_port_ctl_t HPL_PORT_CTL_RST = 5'h00;

    typedef enum logic [1:0] {
        HPL_ST_WAIT = 2'b00,
        HPL_ST_HIGH = 2'b01,
        HPL_ST_LOW  = 2'b10
    } hpl_meas_st_t;

    function automatic logic [16:0] hpl_thr(input logic [1:0] sel);
        case (sel)
            2'h0:    hpl_thr = HPL_THR_SEL0;
            2'h1:    hpl_thr = HPL_THR_SEL1;
            2'h2:    hpl_thr = HPL_THR_SEL2;
            default: hpl_thr = HPL_THR_SEL3;
        endcase
    endfunction : hpl_thr
endpackage : hpl_pkg

// file: src/hpl_pulse_meas.sv
// Purpose: measure low pulses on a synchronised detect line
// Assumes: tick is a one-cycle strobe every microsecond
// Notes:   a pulse is judged on its rising edge
`timescale 1ns/1ps
module hpl_pulse_meas (
    input  wire logic        aclk,      // core clock
    input  wire logic        aresetn,   // sync reset, active low
    input  wire logic        ce,        // clock enable
    input  wire logic        tick,      // measuring tick
    input  wire logic        enable,    // input buffer enable
    input  wire logic        line,      // synchronised level
    input  wire logic [16:0] thr,       // short threshold in ticks
    output logic             short_evt, // short pulse seen
    output logic             long_evt   // long pulse seen
);
    hpl_pkg::hpl_meas_st_t state_r;
    logic [16:0]           cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= hpl_pkg::HPL_ST_WAIT;
        end else if (ce) begin
            if (!enable) begin
                state_r <= hpl_pkg::HPL_ST_WAIT;
            end else begin
                case (state_r)
                    // a line already low when enabled has no known start
                    hpl_pkg::HPL_ST_WAIT: if (line) state_r <= hpl_pkg::HPL_ST_HIGH;
                    hpl_pkg::HPL_ST_HIGH: if (!line) state_r <= hpl_pkg::HPL_ST_LOW;
                    hpl_pkg::HPL_ST_LOW:  if (line) state_r <= hpl_pkg::HPL_ST_HIGH;
                    default:              state_r <= hpl_pkg::HPL_ST_WAIT;
                endcase
            end
        end
    end

    // width counter saturates so 100 ms cannot wrap to short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 17'h00000;
        end else if (ce) begin
            if (state_r != hpl_pkg::HPL_ST_LOW) begin
                cnt_r <= 17'h00000;
            end else if (tick && (cnt_r != 17'h1ffff)) begin
                cnt_r <= cnt_r + 17'h00001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            short_evt <= 1'b0;
            long_evt  <= 1'b0;
        end else if (ce) begin
            short_evt <= 1'b0;
            long_evt  <= 1'b0;
            if (enable && (state_r == hpl_pkg::HPL_ST_LOW) && line) begin
                short_evt <= (cnt_r < thr);
                long_evt  <= !(cnt_r < thr);
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_one_class:
    assert property (!(short_evt && long_evt))
        else $error("short and long flagged together");

    a_buffer_off_quiet:
    assert property (ce && !enable |=> state_r == hpl_pkg::HPL_ST_WAIT ##1 !short_evt && !long_evt)
        else $error("disabled buffer still measuring");

    a_class_short:
    assert property (ce && enable && state_r == hpl_pkg::HPL_ST_LOW && line && cnt_r < thr
                     |=> short_evt && !long_evt)
        else $error("pulse below threshold not short");
endmodule : hpl_pulse_meas

// file: src/hpl_sync3.sv
// Purpose: three-stage synchroniser for one pin
// Assumes: pin is asynchronous to aclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module hpl_sync3 (
    input  wire logic aclk,    // core clock
    input  wire logic aresetn, // sync reset, active low
    input  wire logic ce,      // clock enable
    input  wire logic pin,     // raw pin
    output logic      q        // filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else if (ce && (s2_r == s3_r)) begin
            q <= s3_r;
        end
    end
endmodule : hpl_sync3
